// ==== hdl/icu_pkg.sv ====
// Package with register map, field positions and types of the input capture unit
package icu_pkg;
  localparam int unsigned ICU_AW = 4;
  // Register byte offsets
  localparam logic [ICU_AW-1:0] ICU_OFS_CONTROL = 4'h0;
  localparam logic [ICU_AW-1:0] ICU_OFS_BUFFER  = 4'h4;
  // Field positions in capture_control
  localparam int unsigned ICU_BIT_ENABLE  = 15;
  localparam int unsigned ICU_BIT_IDLE    = 13;
  localparam int unsigned ICU_BIT_FIRST_EDGE_SELECT   = 9;
  localparam int unsigned ICU_BIT_WIDE    = 8;
  localparam int unsigned ICU_BIT_TSEL    = 7;
  localparam int unsigned ICU_BIT_ICNT_LO = 5;
  localparam int unsigned ICU_BIT_OVF     = 4;
  localparam int unsigned ICU_BIT_BNE     = 3;
  localparam int unsigned ICU_BIT_MODE_LO = 0;
  // Writable bits: 15, 13, 9, 8, 7, 6, 5, 2, 1, 0
  localparam logic [31:0] ICU_WR_MASK     = 32'h0000_A3E7;
  localparam logic [31:0] ICU_CTRL_RESET  = 32'h0000_0000;
  localparam int unsigned ICU_DEPTH       = 4;
  localparam logic [1:0]  ICU_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ICU_MODE_OFF     = 3'b000,
    ICU_MODE_EVERY   = 3'b001,
    ICU_MODE_FALL    = 3'b010,
    ICU_MODE_RISE    = 3'b011,
    ICU_MODE_4TH     = 3'b100,
    ICU_MODE_16TH    = 3'b101,
    ICU_MODE_EDGE    = 3'b110,
    ICU_MODE_SPARE   = 3'b111
  } icu_mode_e;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
    logic [31:0] hwdata;
  } icu_ahb_req_s;

  typedef struct packed {
    logic [15:0] timer_second;
    logic [15:0] timer_third;
    logic [31:0] timer_wide;
  } icu_timers_s;
endpackage

// ==== hdl/icu_capture.sv ====
// Input capture unit with AHB-Lite register slave
//
// Summary of operation
// - Enable bit 15 runs the unit; clearing it resets the capture logic and interrupts.
// - Idle-stop bit 13 set halts capture while the CPU is idle.
// - First-edge bit 9 picks rising or falling first, only in mode 110.
// - Width bit 8 records the 32-bit timer, else a 16-bit timer.
// - Timer bit 7 picks third (0) or second (1) timer; ignored when wide.
// - Interrupt count 11, 10, 00 interrupts every fourth, third, second capture.
// - Read-only overflow flag at bit 4.
// - Read-only buffer-not-empty flag at bit 3.
// - Bits 31-16, 14 and 12-10 read as zero.
`timescale 1ns/1ps
`default_nettype none
module icu_capture
  import icu_pkg::*;
#(
  parameter int unsigned DEPTH = icu_pkg::ICU_DEPTH
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire icu_pkg::icu_ahb_req_s ahb_i,
  output logic [31:0]               hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire icu_pkg::icu_timers_s timers_i,
  input  wire logic                 capture_pin_i,
  input  wire logic                 cpu_idle_i,
  output logic                      capture_irq_o
);
  import icu_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  function automatic logic [2:0] icu_every(input logic [1:0] code);
    case (code)
      2'b11:   icu_every = 3'd4;
      2'b10:   icu_every = 3'd3;
      2'b00:   icu_every = 3'd2;
      default: icu_every = 3'd1;
    endcase
  endfunction

  logic [31:0]   ctrl;
  logic [31:0]   fifo_mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          ovf;
  logic          pin_q;
  logic          first_done;
  logic [3:0]    presc;
  logic [2:0]    ev_cnt;
  logic          dp_valid;
  logic          dp_write;
  logic [ICU_AW-1:0] dp_addr;
  logic          dp_pop;

  // Buffer view with the pop of the current data phase already applied
  wire logic [PW:0]   cnt_eff = count - (PW+1)'(dp_pop);
  wire logic [PW-1:0] rd_eff  = dp_pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;

  wire logic enable = ctrl[ICU_BIT_ENABLE];
  wire logic run = enable && !(ctrl[ICU_BIT_IDLE] && cpu_idle_i);
  wire icu_mode_e mode = icu_mode_e'(ctrl[ICU_BIT_MODE_LO +: 3]);
  wire logic rise = capture_pin_i && !pin_q;
  wire logic fall = !capture_pin_i && pin_q;
  wire logic [1:0] icnt = ctrl[ICU_BIT_ICNT_LO +: 2];

  // Edge qualification by mode
  logic edge_hit;
  always_comb begin
    edge_hit = 1'b0;
    case (mode)
      ICU_MODE_EVERY: edge_hit = rise || fall;
      ICU_MODE_FALL:  edge_hit = fall;
      ICU_MODE_RISE:  edge_hit = rise;
      ICU_MODE_4TH:   edge_hit = rise && (presc[1:0] == 2'b11);
      ICU_MODE_16TH:  edge_hit = rise && (presc == 4'hF);
      ICU_MODE_EDGE: begin
        if (first_done) begin
          edge_hit = rise || fall;
        end else begin
          edge_hit = ctrl[ICU_BIT_FIRST_EDGE_SELECT] ? rise : fall;
        end
      end
      default:        edge_hit = 1'b0;
    endcase
  end
  wire logic cap = run && edge_hit;

  // Timestamp source selection
  logic [31:0] stamp;
  always_comb begin
    if (ctrl[ICU_BIT_WIDE]) begin
      stamp = timers_i.timer_wide;
    end else if (ctrl[ICU_BIT_TSEL]) begin
      stamp = {16'h0000, timers_i.timer_second};
    end else begin
      stamp = {16'h0000, timers_i.timer_third};
    end
  end

  // AHB-Lite address phase capture
  wire logic take = ahb_i.hsel && ahb_i.hready && (ahb_i.htrans == ICU_HTRANS_NONSEQ);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= '0;
      dp_pop   <= 1'b0;
    end else begin
      dp_valid <= take;
      dp_write <= take && ahb_i.hwrite;
      dp_addr  <= ahb_i.haddr[ICU_AW-1:0];
      // Pop only what was handed out, so a capture landing meanwhile is kept
      dp_pop   <= take && !ahb_i.hwrite && enable && (cnt_eff != '0)
                  && (ahb_i.haddr[ICU_AW-1:0] == ICU_OFS_BUFFER);
    end
  end

  wire logic buf_read = dp_pop;
  wire logic ctrl_wr = dp_valid && dp_write && (dp_addr == ICU_OFS_CONTROL);
  // A write in its data phase is forwarded to a read whose address phase overlaps it
  wire logic [31:0] ctrl_eff = ctrl_wr ? (ahb_i.hwdata & ICU_WR_MASK) : ctrl;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= ICU_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= ahb_i.hwdata & ICU_WR_MASK;
    end
  end

  // Pin history, prescaler and first-edge tracking
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q      <= 1'b0;
      presc      <= 4'h0;
      first_done <= 1'b0;
    end else begin
      pin_q <= capture_pin_i;
      if (!enable) begin
        presc      <= 4'h0;
        first_done <= 1'b0;
      end else if (run) begin
        if (rise) begin
          presc <= presc + 4'h1;
        end
        if (cap) begin
          first_done <= 1'b1;
        end
      end
    end
  end

  // Capture buffer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (!enable) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (cap && (count != (PW+1)'(DEPTH))) begin
        wr_ptr <= PW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (buf_read) begin
        rd_ptr <= PW'((rd_ptr + 1'b1) % DEPTH);
      end
      count <= count + (PW+1)'(cap && (count != (PW+1)'(DEPTH))) - (PW+1)'(buf_read);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (cap && (count != (PW+1)'(DEPTH))) begin
      fifo_mem[wr_ptr] <= stamp;
    end
  end

  // Overflow: set wins over the clear by a read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf <= 1'b0;
    end else if (!enable) begin
      ovf <= 1'b0;
    end else if (cap && (count == (PW+1)'(DEPTH))) begin
      ovf <= 1'b1;
    end else if (buf_read) begin
      ovf <= 1'b0;
    end
  end

  // Interrupt every N captures, a one-cycle pulse
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_cnt        <= 3'd0;
      capture_irq_o <= 1'b0;
    end else if (!enable) begin
      ev_cnt        <= 3'd0;
      capture_irq_o <= 1'b0;
    end else if (cap) begin
      if (ev_cnt + 3'd1 >= icu_every(icnt)) begin
        ev_cnt        <= 3'd0;
        capture_irq_o <= 1'b1;
      end else begin
        ev_cnt        <= ev_cnt + 3'd1;
        capture_irq_o <= 1'b0;
      end
    end else begin
      capture_irq_o <= 1'b0;
    end
  end

  // Read data registered during the address phase
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ahb_i.haddr[ICU_AW-1:0] == ICU_OFS_CONTROL) begin
      next_rdata = ctrl_eff & ICU_WR_MASK;
      next_rdata[ICU_BIT_OVF] = ovf;
      next_rdata[ICU_BIT_BNE] = (cnt_eff != '0);
    end else if (ahb_i.haddr[ICU_AW-1:0] == ICU_OFS_BUFFER) begin
      next_rdata = (enable && (cnt_eff != '0)) ? fifo_mem[rd_eff] : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take && !ahb_i.hwrite) begin
        hrdata_o <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/icu_capture_properties.sv ====
// Port checker for the input capture unit
`timescale 1ns/1ps
`default_nettype none
module icu_capture_properties #(
  parameter int unsigned DEPTH = 4
) (
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire icu_pkg::icu_ahb_req_s ahb_i,
  input wire logic [31:0]           hrdata_o,
  input wire logic                  hreadyout_o,
  input wire logic                  hresp_o,
  input wire icu_pkg::icu_timers_s  timers_i,
  input wire logic                  capture_pin_i,
  input wire logic                  cpu_idle_i,
  input wire logic                  capture_irq_o
);
  import icu_pkg::*;
  logic [31:0] ctl;
  logic        wr0;
  wire logic   tk  = ahb_i.hsel && ahb_i.hready && ahb_i.htrans == ICU_HTRANS_NONSEQ;
  wire logic   rd0 = tk && !ahb_i.hwrite && ahb_i.haddr[3:0] == ICU_OFS_CONTROL;
  // Control value a read sees, with a write in its data phase already applied
  wire logic [31:0] ctl_now = wr0 ? (ahb_i.hwdata & ICU_WR_MASK) : ctl;
  // Mirror of the writable control bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr0 <= 1'b0;
      ctl <= ICU_CTRL_RESET;
    end else begin
      wr0 <= tk && ahb_i.hwrite && ahb_i.haddr[3:0] == ICU_OFS_CONTROL;
      if (wr0) begin
        ctl <= ahb_i.hwdata & ICU_WR_MASK;
      end
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_UPPER_ZERO: assert property (rd0 |=> hrdata_o[31:16] == 16'h0000)
    else $error("upper control bits nonzero");
  AST_GAP_ZERO: assert property (rd0 |=> !hrdata_o[14] && hrdata_o[12:10] == 3'h0)
    else $error("unused control bits nonzero");
  AST_READBACK: assert property (rd0 |=> (hrdata_o & ICU_WR_MASK) == $past(ctl_now))
    else $error("control readback differs");
  AST_STATUS_OFF: assert property (rd0 && !ctl[15] && !$past(ctl[15]) |=> hrdata_o[4:3] == 2'h0)
    else $error("status set while disabled");
  AST_IRQ_EDGE: assert property (capture_irq_o |-> $past(capture_pin_i) != $past(capture_pin_i, 2))
    else $error("interrupt without pin edge");
  AST_IRQ_EN: assert property (capture_irq_o |-> $past(ctl[15]))
    else $error("interrupt while disabled");
  AST_IRQ_IDLE: assert property (capture_irq_o |-> !($past(ctl[13]) && $past(cpu_idle_i)))
    else $error("interrupt while halted in idle");
  AST_IRQ_PULSE: assert property (capture_irq_o && ctl[6:5] != 2'h1 |=> !capture_irq_o)
    else $error("interrupt on adjacent captures");
  AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus response not ready and okay");
endmodule
bind icu_capture icu_capture_properties #(.DEPTH(DEPTH)) u_icu_capture_properties (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ahb_i(ahb_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .timers_i(timers_i),
  .capture_pin_i(capture_pin_i), .cpu_idle_i(cpu_idle_i), .capture_irq_o(capture_irq_o));
`default_nettype wire

// ==== sim/icu_pin_model.sv ====
// Source of edges on the capture pin
`timescale 1ns/1ps
`default_nettype none
module icu_pin_model (
  input  wire logic core_clk_i,
  input  wire logic step_i,
  output logic      pin_o
);
  // A driven level: it holds between steps
  initial begin
    pin_o = 1'b0;
    forever begin
      @(posedge core_clk_i);
      if (step_i) begin
        pin_o <= !pin_o;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/icu_capture_tb_top.sv ====
// Register-level testbench for the input capture unit
`timescale 1ns/1ps
`default_nettype none
module icu_capture_tb_top;
  import icu_pkg::*;
  logic         clk, rst, rw, step, idle, pin, irq, rdy, rsp, b;
  logic [3:0]   ha;
  logic [1:0]   ht;
  logic [1:0]   interrupt_count [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [31:0]  hd, q, rdat, f;
  logic [31:0]  sel [3] = '{32'h0, 32'h80, 32'h180};
  logic [31:0]  stp [3] = '{32'h2222, 32'h1111, 32'h3333_4444};
  logic [31:0]  per [4] = '{32'h4, 32'h2, 32'h1, 32'h1};
  logic [31:0]  mds [5] = '{32'h2, 32'h3, 32'h4, 32'h5, 32'h7};
  logic [31:0]  mcnt [5] = '{32'h10, 32'h10, 32'h4, 32'h1, 32'h0};
  int           mismatches, comparisons, irqs, base;
  icu_ahb_req_s ahb;
  icu_timers_s  tmr = '{16'h1111, 16'h2222, 32'h3333_4444};
  assign ahb = '{{28'h0, ha}, ht, rw, 3'h2, 1'b1, rdy, hd};
  icu_capture u_icu_capture (.core_clk_i(clk), .rst_i(rst), .ahb_i(ahb), .hrdata_o(rdat),
    .hreadyout_o(rdy), .hresp_o(rsp), .timers_i(tmr), .capture_pin_i(pin),
    .cpu_idle_i(idle), .capture_irq_o(irq));
  icu_pin_model u_icu_pin_model (.core_clk_i(clk), .step_i(step), .pin_o(pin));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  always @(posedge clk) if (irq === 1'b1) irqs++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hrdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    ha <= a;
    ht <= ICU_HTRANS_NONSEQ;
    rw <= w;
    hrdy();
    ht <= 2'h0;
    hd <= d;
    hrdy();
    q = rdat;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic off();
    bus(1'b1, 4'h0, 32'h0);
    @(posedge clk);
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {rst, rw, step, idle, ha, ht, hd} = {4'h8, 38'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    rd(4'h0, 32'h0000_A3E7);
    off();
    $display("register map test done");
    foreach (sel[i]) begin
      bus(1'b1, 4'h0, 32'h0000_8001 | sel[i]);
      edges(1);
      rd(4'h0, 32'h0000_8009 | sel[i]);
      rd(4'h4, stp[i]);
      rd(4'h0, 32'h0000_8001 | sel[i]);
      off();
    end
    $display("timer source test done");
    foreach (interrupt_count[i]) begin
      base = irqs;
      bus(1'b1, 4'h0, {25'h0100, interrupt_count[i], 5'h01});
      edges(4);
      chk(32'(irqs - base), per[i]);
      off();
    end
    $display("interrupt count test done");
    foreach (mds[i]) begin
      base = irqs;
      bus(1'b1, 4'h0, 32'h0000_8020 | mds[i]);
      edges(32);
      chk(32'(irqs - base), mcnt[i]);
      off();
    end
    $display("capture mode test done");
    bus(1'b1, 4'h0, 32'h0000_8001);
    edges(5);
    rd(4'h0, 32'h0000_8019);
    rd(4'h4, 32'h0000_2222);
    rd(4'h0, 32'h0000_8009);
    off();
    idle <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_A001);
    edges(1);
    rd(4'h0, 32'h0000_A001);
    bus(1'b1, 4'h0, 32'h0000_8001);
    edges(1);
    rd(4'h0, 32'h0000_8009);
    idle <= 1'b0;
    off();
    $display("overflow and idle test done");
    for (int k = 0; k < 2; k++) begin
      b = k[0];
      f = {22'h0, pin ^ b, 9'h0};
      bus(1'b1, 4'h0, 32'h0000_8006 | f);
      edges(1);
      rd(4'h0, 32'h0000_8006 | f | {28'h0, b, 3'h0});
      off();
    end
    $display("first edge test done");
    summarize();
  end
endmodule
`default_nettype wire
